// ### usb_switch_supervisor.sv
// per-channel fault supervisor and supply changeover for a dual usb switch
// assumes comparator levels arrive asynchronously; apb master on pclk
//
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "supervisor_defs.svh"

// Functional notes
// R1 - enable high holds both channels off
// R2 - overcurrent above 1V enters current limit
// R3 - overcurrent below 1V enters pulsed short mode
// R4 - each channel has its own blanking counter
// R5 - fault beyond 20ms latches off, flags, autoresets
// R6 - thermal and undervoltage fault immediately, unblanked
// R7 - select high feeds main, low auxiliary
// R8 - make before break, overlap at most 9ms
// R9 - changeover transients never raise a fault
// R10 - short detected: switch off, blank, flag high
// R11 - short cleared before 15ms soft-starts, flag high
// R12 - autoreset sources 25mA, 20ms above 0.5V recovers
// R13 - limit holds until clear, thermal, or timeout; here a drop below 1V also moves limit to short mode
// R14 - cooled thermal fault enters autoreset, flag low
// R15 - normal switching slow, fault turn-off fast; here fast turn-off is driven only for thermal and undervoltage faults
// R16 - flag stays low 20ms after fault clears
// R17 - toggling enable clears a latched channel
// R18 - inputs synchronised, intervals timed from clock
module usb_switch_supervisor
#(
	parameter int unsigned MS_CYCLES = `SUP_MS_CYCLES
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic on_n_pin,
	input wire logic sel_pin,
	input wire logic [1:0] over_current_pin,
	input wire logic [1:0] above_1v_pin,
	input wire logic [1:0] above_half_v_pin,
	input wire logic [1:0] hot_pin,
	input wire logic [1:0] undervolt_pin,
	output logic [1:0] switch_on,
	output logic [1:0] current_ceiling,
	output logic [1:0] pulse_mode,
	output logic [1:0] source_25ma,
	output logic [1:0] fast_turnoff,
	output logic main_supply_on,
	output logic aux_supply_on,
	input wire logic alarm_n_channel_a_in,
	output logic alarm_n_channel_a_out,
	output logic alarm_n_channel_a_oe_n,
	input wire logic alarm_n_channel_b_in,
	output logic alarm_n_channel_b_out,
	output logic alarm_n_channel_b_oe_n
);
	import supervisor_pkg::*;

	sup_state_s q;
	sup_state_s next_q;
	sense_if sense();
	logic setup_phase;
	logic access_wr;
	logic [31:0] read_word;
	logic addr_hit;

	// the tick counters are 8 bits wide
	generate
		if (`SUP_BLANK_TICKS > 255 || `SUP_AUTORESET_TICKS > 255)
		begin : g_bad_ticks
			$error("tick counts exceed counter width");
		end
	endgenerate

	// ----------------------------------------------------------------------
	// input synchronisation and millisecond tick
	// ----------------------------------------------------------------------
	// R18 - synchronised, clock timed
	input_conditioner #(.MS_CYCLES(MS_CYCLES)) u_cond
	(
		.pclk(pclk),
		.presetn(presetn),
		.on_n_pin(on_n_pin),
		.sel_pin(sel_pin),
		.over_current_pin(over_current_pin),
		.above_1v_pin(above_1v_pin),
		.above_half_v_pin(above_half_v_pin),
		.hot_pin(hot_pin),
		.undervolt_pin(undervolt_pin),
		.alarm_pin_in({alarm_n_channel_b_in, alarm_n_channel_a_in}),
		.sense(sense)
	);

	// ----------------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------------
	// read data is captured in setup so the access phase needs no wait
	assign setup_phase = psel && !penable;
	assign access_wr = psel && penable && pwrite && q.pready;
	assign addr_hit = (paddr == `SUP_ADDR_CTRL) || (paddr == `SUP_ADDR_STATUS);

	// status word gathers channel states, pin readback and supply switches
	always_comb
	begin
		read_word = 32'h0;
		if (paddr == `SUP_ADDR_CTRL)
		begin
			read_word[1:0] = q.allow;
		end
		else if (paddr == `SUP_ADDR_STATUS)
		begin
			read_word[`SUP_ST_CH0_LSB +: 6] = q.st[0];
			read_word[`SUP_ST_CH1_LSB +: 6] = q.st[1];
			read_word[`SUP_ST_PIN_LSB +: 2] = sense.alarm_pin;
			read_word[`SUP_ST_MAIN_BIT] = q.main_on;
			read_word[`SUP_ST_AUX_BIT] = q.aux_on;
			read_word[`SUP_ST_ONN_BIT] = sense.on_n;
			read_word[`SUP_ST_BUSY_BIT] = q.busy;
		end
	end

	// ----------------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------------
	always_comb
	begin
		logic fault_hard;
		fault_hard = 1'b0;
		next_q = q;

		// bus slave: always ready once out of reset, error on unmapped address
		next_q.pready = 1'b1;
		if (setup_phase)
		begin
			next_q.prdata = read_word;
			next_q.pslverr = !addr_hit;
		end
		if (access_wr && paddr == `SUP_ADDR_CTRL)
		begin
			next_q.allow = pwdata[1:0];
		end

		// per-channel fault machine
		for (int i = 0; i < 2; i++)
		begin
			// R6 - thermal and undervoltage unblanked
			fault_hard = sense.hot[i] || sense.undervolt[i];
			case (q.st[i])
				CH_OFF:
				begin
					next_q.blank[i] = '0;
					next_q.ar[i] = '0;
					next_q.st[i] = CH_RUN;
				end
				CH_RUN:
				begin
					next_q.blank[i] = '0;
					if (fault_hard)
					begin
						next_q.st[i] = CH_HOT;
					end
					else if (sense.over_current[i])
					begin
						// R2 - limit above 1V
						// R3 - short below 1V
						// R4 - blanking starts here
						next_q.st[i] = sense.above_1v[i] ? CH_LIMIT : CH_SHORT;
						next_q.pulse[i] = 1'b0;
					end
				end
				CH_LIMIT:
				begin
					// R13 - first of clear, hard fault, drop below 1V, timeout
					if (fault_hard)
					begin
						next_q.st[i] = CH_HOT;
					end
					else if (!sense.over_current[i])
					begin
						next_q.st[i] = CH_RUN;
					end
					else if (!sense.above_1v[i])
					begin
						next_q.st[i] = CH_SHORT;
					end
					else if (sense.tick)
					begin
						// R5 - latch after 20ms
						// R9 - 9ms changeover stays inside blanking
						if (q.blank[i] >= 8'(`SUP_BLANK_TICKS - 1))
						begin
							next_q.st[i] = CH_AUTORESET;
							next_q.ar[i] = '0;
						end
						else
						begin
							next_q.blank[i] = q.blank[i] + 8'h01;
						end
					end
				end
				CH_SHORT:
				begin
					if (fault_hard)
					begin
						next_q.st[i] = CH_HOT;
					end
					else if (!sense.over_current[i])
					begin
						// R11 - early clear soft-starts
						if (q.blank[i] < 8'(`SUP_SHORT_RECOVER_TICKS))
						begin
							next_q.st[i] = CH_RUN;
						end
					end
					else if (sense.above_1v[i])
					begin
						next_q.st[i] = CH_LIMIT;
					end
					if (next_q.st[i] == CH_SHORT && sense.tick)
					begin
						// R10 - off first, then pulses
						next_q.pulse[i] = !q.pulse[i];
						// R5 - latch after 20ms
						if (q.blank[i] >= 8'(`SUP_BLANK_TICKS - 1))
						begin
							next_q.st[i] = CH_AUTORESET;
							next_q.ar[i] = '0;
						end
						else
						begin
							next_q.blank[i] = q.blank[i] + 8'h01;
						end
					end
				end
				CH_HOT:
				begin
					// R14 - cooled enters autoreset
					if (!fault_hard)
					begin
						next_q.st[i] = CH_AUTORESET;
						next_q.ar[i] = '0;
					end
				end
				CH_AUTORESET:
				begin
					// R12 - 20ms above 0.5V recovers
					// R16 - flag held low meanwhile
					if (fault_hard)
					begin
						next_q.st[i] = CH_HOT;
					end
					else if (!sense.above_half_v[i])
					begin
						next_q.ar[i] = '0;
					end
					else if (sense.tick)
					begin
						if (q.ar[i] >= 8'(`SUP_AUTORESET_TICKS - 1))
						begin
							next_q.st[i] = CH_RUN;
						end
						else
						begin
							next_q.ar[i] = q.ar[i] + 8'h01;
						end
					end
				end
				default:
				begin
					next_q.st[i] = CH_OFF;
				end
			endcase

			// R1 - enable high forces off
			// R17 - off state clears the latch
			if (sense.on_n || !q.allow[i])
			begin
				next_q.st[i] = CH_OFF;
			end

			// R15 - fast turn-off only under hard faults
			next_q.sw[i] = (next_q.st[i] == CH_RUN) || (next_q.st[i] == CH_LIMIT) ||
				((next_q.st[i] == CH_SHORT) && next_q.pulse[i]);
			next_q.ceil[i] = (next_q.st[i] == CH_LIMIT);
			next_q.pmode[i] = (next_q.st[i] == CH_SHORT);
			next_q.src[i] = (next_q.st[i] == CH_AUTORESET);
			next_q.fast[i] = (next_q.st[i] == CH_HOT);
			next_q.alarm[i] = !((next_q.st[i] == CH_HOT) || (next_q.st[i] == CH_AUTORESET));
		end

		// R7 - select high main, low auxiliary
		// R8 - make before break
		if (sense.on_n)
		begin
			next_q.busy = 1'b0;
			next_q.applied = sense.sel;
			next_q.main_on = 1'b0;
			next_q.aux_on = 1'b0;
		end
		else if (q.busy)
		begin
			if (sense.tick)
			begin
				if (q.ovl >= 8'(`SUP_OVERLAP_TICKS - 1))
				begin
					next_q.busy = 1'b0;
					next_q.main_on = q.applied;
					next_q.aux_on = !q.applied;
				end
				else
				begin
					next_q.ovl = q.ovl + 8'h01;
				end
			end
		end
		else if ((sense.sel != q.applied) && (q.main_on || q.aux_on))
		begin
			next_q.applied = sense.sel;
			next_q.busy = 1'b1;
			next_q.ovl = '0;
			next_q.main_on = 1'b1;
			next_q.aux_on = 1'b1;
		end
		else
		begin
			next_q.applied = sense.sel;
			next_q.main_on = sense.sel;
			next_q.aux_on = !sense.sel;
		end
	end

	// ----------------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			q <= '0;
			q.st[0] <= CH_OFF;
			q.st[1] <= CH_OFF;
			q.alarm <= 2'h3;
			q.allow <= `SUP_CTRL_ALLOW_RESET;
			q.applied <= 1'b1;
		end
		else
		begin
			q <= next_q;
		end
	end

	// ----------------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------------
	// open-drain flags: the pad is only ever pulled low
	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign switch_on = q.sw;
	assign current_ceiling = q.ceil;
	assign pulse_mode = q.pmode;
	assign source_25ma = q.src;
	assign fast_turnoff = q.fast;
	assign main_supply_on = q.main_on;
	assign aux_supply_on = q.aux_on;
	assign alarm_n_channel_a_out = 1'b0;
	assign alarm_n_channel_a_oe_n = q.alarm[0];
	assign alarm_n_channel_b_out = 1'b0;
	assign alarm_n_channel_b_oe_n = q.alarm[1];

	// ----------------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------------
	// overlap watchdog in cycles; both supplies closed never reaches 9ms
	logic [31:0] both_cnt;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			both_cnt <= 32'h0;
		end
		else
		begin
			both_cnt <= (q.main_on && q.aux_on) ? both_cnt + 32'h1 : 32'h0;
		end
	end

	property p_overlap_bound;
		@(posedge pclk) disable iff (!presetn)
		both_cnt < 32'(`SUP_OVERLAP_MS * MS_CYCLES);
	endproperty
	a_overlap_bound: assert property (p_overlap_bound) else $error("supply overlap too long"); // R8

	property p_sel_follow;
		@(posedge pclk) disable iff (!presetn)
		(!sense.on_n && !q.busy && sense.sel == q.applied)[*2] |=> (q.main_on == q.applied);
	endproperty
	a_sel_follow: assert property (p_sel_follow) else $error("supply does not follow select"); // R7

	for (genvar gi = 0; gi < 2; gi++)
	begin : g_chk
		property p_enable_off;
			@(posedge pclk) disable iff (!presetn)
			sense.on_n |=> !q.sw[gi] && q.alarm[gi];
		endproperty
		a_enable_off: assert property (p_enable_off) else $error("channel on while disabled"); // R1

		property p_hard_fault;
			@(posedge pclk) disable iff (!presetn)
			(sense.hot[gi] && !sense.on_n && q.allow[gi] && q.st[gi] != CH_OFF) |=>
				(!q.alarm[gi] && !q.sw[gi] && q.fast[gi]);
		endproperty
		a_hard_fault: assert property (p_hard_fault) else $error("thermal fault not immediate"); // R6

		property p_limit_mode;
			@(posedge pclk) disable iff (!presetn)
			(q.st[gi] == CH_LIMIT) |-> (q.ceil[gi] && q.sw[gi] && q.alarm[gi]);
		endproperty
		a_limit_mode: assert property (p_limit_mode) else $error("limit outputs wrong"); // R2

		property p_blank_latch;
			@(posedge pclk) disable iff (!presetn)
			$rose(q.src[gi]) && ($past(q.st[gi]) != CH_HOT) |->
				$past(q.blank[gi]) == 8'(`SUP_BLANK_TICKS - 1);
		endproperty
		a_blank_latch: assert property (p_blank_latch) else $error("latched before blanking"); // R5

		property p_autoreset_release;
			@(posedge pclk) disable iff (!presetn)
			$rose(q.alarm[gi]) && $past(q.st[gi]) == CH_AUTORESET &&
				q.st[gi] == CH_RUN |->
				$past(q.ar[gi]) == 8'(`SUP_AUTORESET_TICKS - 1) && q.sw[gi];
		endproperty
		a_autoreset_release: assert property (p_autoreset_release) else $error("early release"); // R12

		property p_short_flag_high;
			@(posedge pclk) disable iff (!presetn)
			(q.st[gi] == CH_SHORT) |-> (q.alarm[gi] && q.pmode[gi] && !q.src[gi]);
		endproperty
		a_short_flag_high: assert property (p_short_flag_high) else $error("short flagged"); // R10

		property p_cooled;
			@(posedge pclk) disable iff (!presetn)
			(q.st[gi] == CH_HOT && !sense.hot[gi] && !sense.undervolt[gi] && !sense.on_n &&
				q.allow[gi]) |=> (q.src[gi] && !q.alarm[gi]);
		endproperty
		a_cooled: assert property (p_cooled) else $error("cooled channel not in autoreset"); // R14
	end
endmodule

`default_nettype wire

// ### supervisor_defs.svh
// constants for the dual usb switch fault supervisor: offsets, resets, timing
// assumes a single supervisor clock; all millisecond figures become tick counts
`ifndef SUPERVISOR_DEFS_SVH
`define SUPERVISOR_DEFS_SVH

// ----------------------------------------------------------------------
// clock and millisecond divider
// ----------------------------------------------------------------------
`define SUP_CLK_HZ 50000000
`define SUP_MS_CYCLES (`SUP_CLK_HZ / 1000)

// ----------------------------------------------------------------------
// fault and changeover timing, in milliseconds and in millisecond ticks
// ----------------------------------------------------------------------
`define SUP_BLANK_MS 20
`define SUP_BLANK_TICKS (`SUP_BLANK_MS + 1)
`define SUP_SHORT_RECOVER_MS 15
`define SUP_SHORT_RECOVER_TICKS (`SUP_SHORT_RECOVER_MS)
`define SUP_AUTORESET_MS 20
`define SUP_AUTORESET_TICKS (`SUP_AUTORESET_MS + 1)
`define SUP_OVERLAP_MS 9
`define SUP_OVERLAP_TICKS (`SUP_OVERLAP_MS - 1)

// ----------------------------------------------------------------------
// register map, byte addresses
// ----------------------------------------------------------------------
`define SUP_ADDR_CTRL 8'h00
`define SUP_ADDR_STATUS 8'h04
`define SUP_CTRL_ALLOW_RESET 2'h3

// ----------------------------------------------------------------------
// status field positions
// ----------------------------------------------------------------------
`define SUP_ST_CH0_LSB 0
`define SUP_ST_CH1_LSB 6
`define SUP_ST_PIN_LSB 12
`define SUP_ST_MAIN_BIT 14
`define SUP_ST_AUX_BIT 15
`define SUP_ST_ONN_BIT 16
`define SUP_ST_BUSY_BIT 17

// number of synchronised pin inputs
`define SUP_SYNC_W 14

`endif

// ### supervisor_pkg.sv
// types shared by the supervisor top and its input conditioner
// assumes supervisor_defs.svh supplies the numeric constants
package supervisor_pkg;

	// one-hot channel states
	typedef enum logic [5:0]
	{
		CH_OFF = 6'h01,
		CH_RUN = 6'h02,
		CH_LIMIT = 6'h04,
		CH_SHORT = 6'h08,
		CH_HOT = 6'h10,
		CH_AUTORESET = 6'h20
	} chan_state_e;

	typedef logic [7:0] ms_count_t;

	// complete state of the supervisor top
	typedef struct packed
	{
		chan_state_e [1:0] st;
		ms_count_t [1:0] blank;
		ms_count_t [1:0] ar;
		logic [1:0] pulse;
		logic [1:0] sw;
		logic [1:0] ceil;
		logic [1:0] pmode;
		logic [1:0] src;
		logic [1:0] fast;
		logic [1:0] alarm;
		logic applied;
		logic busy;
		ms_count_t ovl;
		logic main_on;
		logic aux_on;
		logic [1:0] allow;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} sup_state_s;

	// complete state of the input conditioner
	typedef struct packed
	{
		logic [13:0] meta;
		logic [13:0] sync;
		logic [31:0] div;
		logic tick;
	} cond_state_s;

endpackage

// ### sense_if.sv
// carrier for synchronised comparator levels and the millisecond tick
// assumes producer and consumer share pclk
`timescale 1ns/1ps
`default_nettype none

interface sense_if;
	logic on_n;
	logic sel;
	logic tick;
	logic [1:0] over_current;
	logic [1:0] above_1v;
	logic [1:0] above_half_v;
	logic [1:0] hot;
	logic [1:0] undervolt;
	logic [1:0] alarm_pin;

	modport producer
	(
		output on_n, sel, tick, over_current, above_1v, above_half_v, hot, undervolt,
		alarm_pin
	);
	modport consumer
	(
		input on_n, sel, tick, over_current, above_1v, above_half_v, hot, undervolt,
		alarm_pin
	);
endinterface

`default_nettype wire

// ### input_conditioner.sv
// two-flop synchronisers for every pin level and the millisecond tick divider
// assumes all pin inputs are asynchronous to pclk
`timescale 1ns/1ps
`default_nettype none
`include "supervisor_defs.svh"

module input_conditioner
#(
	parameter int unsigned MS_CYCLES = `SUP_MS_CYCLES
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic on_n_pin,
	input wire logic sel_pin,
	input wire logic [1:0] over_current_pin,
	input wire logic [1:0] above_1v_pin,
	input wire logic [1:0] above_half_v_pin,
	input wire logic [1:0] hot_pin,
	input wire logic [1:0] undervolt_pin,
	input wire logic [1:0] alarm_pin_in,
	sense_if.producer sense
);
	import supervisor_pkg::*;

	cond_state_s q;
	cond_state_s next_q;

	// the divider needs at least two cycles to make a one-cycle tick
	generate
		if (MS_CYCLES < 2)
		begin : g_bad_div
			$error("MS_CYCLES must be at least 2");
		end
	endgenerate

	// ----------------------------------------------------------------------
	// synchronisers and divider
	// ----------------------------------------------------------------------
	// first stage feeds only the second stage, never logic
	always_comb
	begin
		next_q = q;
		next_q.meta = {alarm_pin_in, undervolt_pin, hot_pin, above_half_v_pin,
			above_1v_pin, over_current_pin, sel_pin, on_n_pin};
		next_q.sync = q.meta;
		next_q.tick = 1'b0;
		if (q.div >= MS_CYCLES - 1)
		begin
			next_q.div = '0;
			next_q.tick = 1'b1;
		end
		else
		begin
			next_q.div = q.div + 32'h1;
		end
	end

	// on_n resets to high so the channels stay off until the pin is seen
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			q <= '0;
			q.meta <= 14'h0001;
			q.sync <= 14'h0001;
		end
		else
		begin
			q <= next_q;
		end
	end

	// ----------------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------------
	assign sense.on_n = q.sync[0];
	assign sense.sel = q.sync[1];
	assign sense.over_current = q.sync[3:2];
	assign sense.above_1v = q.sync[5:4];
	assign sense.above_half_v = q.sync[7:6];
	assign sense.hot = q.sync[9:8];
	assign sense.undervolt = q.sync[11:10];
	assign sense.alarm_pin = q.sync[13:12];
	assign sense.tick = q.tick;
endmodule

`default_nettype wire

// ### flag_host_model.sv
// partner: the host side of the two open-drain alarm pads, with their pull-ups
// assumes oe_n low means the device pulls its pad low
`timescale 1ns/1ps
`default_nettype none

module flag_host_model
(
	input wire logic oe_n_a,
	input wire logic oe_n_b,
	output logic pad_a,
	output logic pad_b
);
	// pad low on fault
	// a released pad goes to the pull-up level, so a stale low never lingers
	assign pad_a = oe_n_a ? 1'b1 : 1'b0;
	assign pad_b = oe_n_b ? 1'b1 : 1'b0;
endmodule

`default_nettype wire

// ### tb_top.sv
// self-checking bench for the supervisor: apb registers, channel faults, changeover
// assumes MS_CYCLES is cut to 10, so one millisecond is ten clocks
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	localparam int MS = 10;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr;
	logic on_n_pin = 1'b1;
	logic sel_pin = 1'b1;
	logic [1:0] oc = 2'h0;
	logic [1:0] a1v = 2'h3;
	logic [1:0] ahv = 2'h0;
	logic [1:0] hot = 2'h0;
	logic [1:0] uv = 2'h0;
	logic [1:0] sw, ceil, pm, src, fast;
	logic main_on, aux_on, out_a, out_b, oe_a, oe_b, pad_a, pad_b;
	logic [13:0] obs;
	logic [27:0] pin_q[$];
	logic [32:0] rd_q[$];
	logic [32:0] rd_got;
	logic [31:0] seed = 32'd75;
	int n_mismatch = 0;
	int num_checks = 0;
	int cycles = 0;
	event pin_ev, rd_ev;

	always #10 pclk = ~pclk;
	// one vector of every channel and supply output, for masked compares
	assign obs = {sw, ceil, pm, src, fast, main_on, aux_on, oe_b, oe_a};

	usb_switch_supervisor #(.MS_CYCLES(MS)) usb_switch_supervisor_i
	(
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .on_n_pin(on_n_pin), .sel_pin(sel_pin), .over_current_pin(oc),
		.above_1v_pin(a1v), .above_half_v_pin(ahv), .hot_pin(hot), .undervolt_pin(uv),
		.switch_on(sw), .current_ceiling(ceil), .pulse_mode(pm), .source_25ma(src),
		.fast_turnoff(fast), .main_supply_on(main_on), .aux_supply_on(aux_on),
		.alarm_n_channel_a_in(pad_a), .alarm_n_channel_a_out(out_a),
		.alarm_n_channel_a_oe_n(oe_a), .alarm_n_channel_b_in(pad_b),
		.alarm_n_channel_b_out(out_b), .alarm_n_channel_b_oe_n(oe_b)
	);
	flag_host_model flag_host_model_i
	(
		.oe_n_a(oe_a), .oe_n_b(oe_b), .pad_a(pad_a), .pad_b(pad_b)
	);

	// ------------------------------------------------------------
	// reporting and compares
	// ------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic bad(input string m);
		n_mismatch++;
		$display("CHECK FAILED at %0t: %s", $time, m);
	endtask
	task automatic chk_pins(input logic [27:0] e);
		num_checks++;
		if ((obs & e[27:14]) !== e[13:0])
			bad($sformatf("pins %h want %h", obs & e[27:14], e[13:0]));
		// open-drain pads may only ever be driven low
		if ({out_b, out_a} !== 2'b00)
			bad("flag drive level not low");
	endtask
	task automatic chk_read(input logic [32:0] e);
		num_checks++;
		if (rd_got !== e)
			bad($sformatf("apb %h want %h", rd_got, e));
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// monitors take the oldest note as each result is presented
	always @(pin_ev)
		chk_pins(pin_q.pop_front());
	always @(rd_ev)
		chk_read(rd_q.pop_front());

	// a hang counts as a mismatch; the whole run needs under a thousand clocks
	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			bad("timeout");
			final_report();
		end
	end

	// ------------------------------------------------------------
	// drivers
	// ------------------------------------------------------------
	// wait up to n cycles for the masked outputs, then present them
	task automatic pins(input logic [13:0] m, input logic [13:0] v, input int n);
		int i;
		i = 0;
		@(negedge pclk);
		while ((obs & m) !== v && i < n)
		begin
			@(negedge pclk);
			i++;
		end
		pin_q.push_back({m, v});
		->pin_ev;
	endtask
	// one apb transfer; the request holds until pready is seen high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [32:0] ex);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// no wait count assumed: only the bench timeout ends a stuck transfer
		while (pready !== 1'b1)
		begin
			@(posedge pclk);
		end
		rd_got = {pslverr, wr ? 32'h0 : prdata};
		psel <= 1'b0;
		penable <= 1'b0;
		rd_q.push_back(ex);
		->rd_ev;
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		repeat (4) @(posedge pclk);
		pins(14'h3FFF, 14'h0003, 0);
		@(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		on_n_pin <= 1'b0;
		pins(14'h3FFF, 14'h300B, 8);
		seed = lfsr(seed);
		apb(1'b0, 8'h00, 32'h0, 33'h3);
		apb(1'b1, 8'h00, seed | 32'h3, 33'h0);
		apb(1'b0, 8'h00, 32'h0, 33'h3);
		apb(1'b0, 8'h08, 32'h0, {1'b1, 32'h0});
		apb(1'b1, 8'h04, seed, 33'h0);
		apb(1'b0, 8'h04, 32'h0, 33'h7082);
		apb(1'b1, 8'h00, 32'h2, 33'h0);
		pins(14'h1001, 14'h0001, 8);
		apb(1'b1, 8'h00, 32'h3, 33'h0);
		pins(14'h3FFF, 14'h300B, 8);
		$display("test registers done");
		@(posedge pclk);
		oc <= 2'h1;
		pins(14'h0F03, 14'h0403, 4);
		@(posedge pclk);
		oc <= 2'h0;
		pins(14'h3FFF, 14'h300B, 4);
		@(posedge pclk);
		oc <= 2'h1;
		pins(14'h0C03, 14'h0403, 4);
		repeat (19 * MS) @(negedge pclk);
		pins(14'h0C03, 14'h0403, 0);
		pins(14'h1041, 14'h0040, 4 * MS);
		@(posedge pclk);
		oc <= 2'h0;
		ahv <= 2'h1;
		repeat (19 * MS) @(negedge pclk);
		pins(14'h1041, 14'h0040, 0);
		pins(14'h1041, 14'h1001, 4 * MS);
		$display("test current limit done");
		@(posedge pclk);
		a1v <= 2'h2;
		oc <= 2'h1;
		pins(14'h1101, 14'h0101, 4);
		repeat (5 * MS) @(negedge pclk);
		pins(14'h0101, 14'h0101, 0);
		@(posedge pclk);
		oc <= 2'h0;
		a1v <= 2'h3;
		pins(14'h1101, 14'h1001, 2 * MS);
		$display("test short done");
		@(posedge pclk);
		hot <= 2'h2;
		pins(14'h3023, 14'h1021, 4);
		@(posedge pclk);
		hot <= 2'h0;
		pins(14'h2082, 14'h0080, 4);
		@(posedge pclk);
		uv <= 2'h1;
		pins(14'h1011, 14'h0010, 4);
		@(posedge pclk);
		uv <= 2'h0;
		on_n_pin <= 1'b1;
		pins(14'h300C, 14'h0000, 6);
		@(posedge pclk);
		on_n_pin <= 1'b0;
		pins(14'h3FFF, 14'h300B, 8);
		$display("test thermal and enable done");
		for (int k = 0; k < 2; k++)
		begin
			@(posedge pclk);
			sel_pin <= k[0];
			pins(14'h000F, 14'h000F, 6);
			repeat (6 * MS) @(negedge pclk);
			pins(14'h000F, 14'h000F, 0);
			pins(14'h000F, k ? 14'h000B : 14'h0007, 3 * MS);
		end
		$display("test changeover done");
		final_report();
	end
endmodule

`default_nettype wire
